// ===== design/gpls_pin_mux.sv
`timescale 1ns/1ps
module gpls_pin_mux (
    gpls_mux_if.mux mx
);

    // ------------------------------------------------------------------
    // Per-pin function decode
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < gpls_pkg::PINS; i++)
        begin : g_pin
            if (i >= gpls_pkg::HALF)
            begin : g_up
                assign mx.gpioMode[i] = !((mx.segField >= gpls_pkg::SEG_UP_LO) &&
                                          (mx.segField <= gpls_pkg::SEG_UP_HI));
            end
            else
            begin : g_low
                assign mx.gpioMode[i] = !((mx.segField >= gpls_pkg::SEG_LOW_LO) &&
                                          (mx.segField <= gpls_pkg::SEG_LOW_HI));
            end
        end
    endgenerate

endmodule // gpls_pin_mux

// ===== design/gpls_port.sv
`timescale 1ns/1ps
// Contract
// - Reset clears the data latch, direction and pull-up enable registers to zero.
// - A data read returns the latched bit for every pin set as output.
// - A data read returns the pin level for every pin set as input.
// - A direction bit of one drives the pin with its latched bit, zero makes it an input.
// - The direction register is write-only and always reads as all ones.
// - Direction and data only act on a pin while the segment field leaves it as I/O.
// - A pull-up is on only for an input pin whose pull-up enable bit is one.
// - Upper pins carry segment pin plus nine while the field holds four to eleven.
// - Lower pins carry segment pin plus nine while the field holds three to ten.
// - Pins float in reset, hold in sleep modes and work in active modes.
// - In standby and watch pins float, pulled high where the pull-up is on.
// - The pull-up enable register is readable and writable, one bit per pin.
module gpls_port #(
    parameter int PINS   = gpls_pkg::PINS,
    parameter int ADDR_W = gpls_pkg::ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [3:0]        segField,
    input  wire logic [2:0]        powerMode,
    input  wire logic [PINS-1:0]   segData,
    input  wire logic [PINS-1:0]   pinIn,
    output logic      [PINS-1:0]   pinOut,
    output logic      [PINS-1:0]   pinOe,
    output logic      [PINS-1:0]   pullupOn
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The segment ranges are split into two fixed halves, so only one
    // port width can be served.
    if (PINS != gpls_pkg::PINS)
    begin : g_bad_pins
        $error("gpls_port supports exactly eight pins");
    end
    if (ADDR_W < gpls_pkg::IDX_W + 2)
    begin : g_bad_addr
        $error("gpls_port address bus too narrow for the register map");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PINS-1:0]     latch;
        logic [PINS-1:0]     dir;
        logic [PINS-1:0]     pue;
        logic [PINS-1:0]     pinOut;
        logic [PINS-1:0]     pinOe;
        logic [PINS-1:0]     pullupOn;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        gpls_pkg::gpls_bus_t bus;
    } gpls_state_t;

    gpls_state_t st_reg;
    gpls_state_t st_next;

    // ------------------------------------------------------------------
    // Segment decode
    // ------------------------------------------------------------------
    gpls_mux_if mx ();

    assign mx.segField = segField;

    gpls_pin_mux u_mux (
        .mx (mx)
    );

    logic [PINS-1:0] gpio;
    assign gpio = mx.gpioMode;

    // ------------------------------------------------------------------
    // Address decode and read data
    // ------------------------------------------------------------------
    logic [gpls_pkg::IDX_W-1:0] idx;
    logic                       aligned;
    logic                       hitData;
    logic                       hitPull;
    logic                       hitDir;
    logic                       hit;
    logic [31:0]                readVal;
    logic                       doWrite;

    assign idx     = paddr[gpls_pkg::IDX_W+1:2];
    assign aligned = paddr[1:0] == gpls_pkg::WORD_LANE;
    assign hitData = aligned && (idx == gpls_pkg::IDX_DATA);
    assign hitPull = aligned && (idx == gpls_pkg::IDX_PULLUP);
    assign hitDir  = aligned && (idx == gpls_pkg::IDX_DIR);
    assign hit     = hitData || hitPull || hitDir;

    // A write lands only on the edge that completes the access phase.
    assign doWrite = psel && penable && pwrite && st_reg.pready && hit;

    always_comb
    begin
        readVal = gpls_pkg::READ_ZERO;
        if (hitData)
        begin
            readVal[PINS-1:0] = (st_reg.dir & st_reg.latch) |
                                (~st_reg.dir & pinIn);
        end
        else if (hitPull)
        begin
            readVal[PINS-1:0] = st_reg.pue;
        end
        else if (hitDir)
        begin
            readVal[PINS-1:0] = gpls_pkg::DIR_READ;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next         = st_reg;
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;

        unique case (st_reg.bus)
            gpls_pkg::GPLS_IDLE:
            begin
                if (psel && penable)
                begin
                    st_next.bus     = gpls_pkg::GPLS_RESP;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = !hit;
                    st_next.prdata  = pwrite ? gpls_pkg::READ_ZERO : readVal;
                end
            end
            gpls_pkg::GPLS_RESP:
            begin
                st_next.bus = gpls_pkg::GPLS_IDLE;
            end
        endcase

        if (doWrite && hitData)
        begin
            st_next.latch = pwdata[PINS-1:0];
        end
        if (doWrite && hitDir)
        begin
            st_next.dir = pwdata[PINS-1:0];
        end
        if (doWrite && hitPull)
        begin
            st_next.pue = pwdata[PINS-1:0];
        end

        // Pin outputs follow the new register values so that a write
        // reaches the pin on the very edge that completes it.
        unique case (powerMode)
            gpls_pkg::GPLS_ACTIVE,
            gpls_pkg::GPLS_SUBACTIVE:
            begin
                st_next.pinOe    = (gpio & st_next.dir) | ~gpio;
                st_next.pinOut   = (gpio & st_next.latch) | (~gpio & segData);
                st_next.pullupOn = gpio & ~st_next.dir & st_next.pue;
            end
            gpls_pkg::GPLS_SLEEP,
            gpls_pkg::GPLS_SUBSLEEP:
            begin
                st_next.pinOe    = st_reg.pinOe;
                st_next.pinOut   = st_reg.pinOut;
                st_next.pullupOn = st_reg.pullupOn;
            end
            default:
            begin
                // Standby, watch and any unknown code float the pins; the
                // pull-up alone lifts a pin to a high level.
                st_next.pinOe    = '0;
                st_next.pinOut   = '0;
                st_next.pullupOn = gpio & ~st_next.dir & st_next.pue;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg.latch    <= gpls_pkg::RESET_BYTE;
            st_reg.dir      <= gpls_pkg::RESET_BYTE;
            st_reg.pue      <= gpls_pkg::RESET_BYTE;
            st_reg.pinOut   <= '0;
            st_reg.pinOe    <= '0;
            st_reg.pullupOn <= '0;
            st_reg.prdata   <= gpls_pkg::READ_ZERO;
            st_reg.pready   <= 1'b0;
            st_reg.pslverr  <= 1'b0;
            st_reg.bus      <= gpls_pkg::GPLS_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prdata   = st_reg.prdata;
    assign pready   = st_reg.pready;
    assign pslverr  = st_reg.pslverr;
    assign pinOut   = st_reg.pinOut;
    assign pinOe    = st_reg.pinOe;
    assign pullupOn = st_reg.pullupOn;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Checks on outputs use the previous cycle's mode and decode because
    // the outputs are registered one edge behind them.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic accRead;
    logic accWrite;
    logic runMode;
    logic lowMode;
    logic sleepMode;

    assign accRead   = psel && penable && !pwrite && !st_reg.pready;
    assign accWrite  = psel && penable && pwrite && st_reg.pready;
    assign runMode   = (powerMode == gpls_pkg::GPLS_ACTIVE) ||
                       (powerMode == gpls_pkg::GPLS_SUBACTIVE);
    assign sleepMode = (powerMode == gpls_pkg::GPLS_SLEEP) ||
                       (powerMode == gpls_pkg::GPLS_SUBSLEEP);
    assign lowMode   = (powerMode == gpls_pkg::GPLS_STANDBY) ||
                       (powerMode == gpls_pkg::GPLS_WATCH);

    a_reset_clear: assert property (
        $fell(rst) |-> (st_reg.latch == '0) && (st_reg.dir == '0) &&
                       (st_reg.pue == '0) && (pinOe == '0) && (pullupOn == '0))
        else $error("registers or pins not cleared by reset");

    a_read_latched: assert property (
        (accRead && hitData) |=>
            ((prdata[PINS-1:0] & $past(st_reg.dir)) == ($past(st_reg.latch) & $past(st_reg.dir))))
        else $error("output bit did not read back the latch");

    a_read_pin: assert property (
        (accRead && hitData) |=>
            ((prdata[PINS-1:0] & ~$past(st_reg.dir)) == ($past(pinIn) & ~$past(st_reg.dir))))
        else $error("input bit did not read the pin level");

    a_drive_output: assert property (
        runMode |=> (pinOe == (($past(gpio) & st_reg.dir) | ~$past(gpio))) &&
                    (((pinOut ^ st_reg.latch) & $past(gpio) & st_reg.dir) == '0))
        else $error("pin drive does not follow direction and latch");

    a_dir_reads_ones: assert property (
        (accRead && hitDir) |=> pready && (prdata == 32'h000000ff) && !pslverr)
        else $error("direction register did not read as ones");

    a_seg_override: assert property (
        runMode |=> (((pinOut ^ $past(segData)) & ~$past(gpio)) == '0) &&
                    ((pinOe | $past(gpio)) == '1))
        else $error("segment pin not driven with segment data");

    a_pullup_gate: assert property (
        (runMode || lowMode) |=> (pullupOn == ($past(gpio) & ~st_reg.dir & st_reg.pue)))
        else $error("pull-up state wrong");

    a_upper_range: assert property (
        gpio[7:4] == (((segField >= 4'h4) && (segField <= 4'hb)) ? 4'h0 : 4'hf))
        else $error("upper half segment decode wrong");

    a_lower_range: assert property (
        gpio[3:0] == (((segField >= 4'h3) && (segField <= 4'ha)) ? 4'h0 : 4'hf))
        else $error("lower half segment decode wrong");

    a_sleep_hold: assert property (
        sleepMode |=> $stable(pinOe) && $stable(pinOut) && $stable(pullupOn))
        else $error("pins changed during sleep");

    a_standby_float: assert property (
        lowMode |=> (pinOe == '0))
        else $error("pins driven in standby or watch");

    a_pullup_write: assert property (
        (accWrite && hitPull) |=> (st_reg.pue == $past(pwdata[PINS-1:0])))
        else $error("pull-up enable write lost");

    a_latch_write: assert property (
        (accWrite && hitData && runMode) |=>
            (st_reg.latch == $past(pwdata[PINS-1:0])) &&
            (((pinOut ^ st_reg.latch) & st_reg.dir & $past(gpio)) == '0))
        else $error("data write did not reach the pin on its edge");

    a_bus_answer: assert property (
        (psel && penable && !st_reg.pready) |=> pready ##1 !pready)
        else $error("bus answer not one wait state");

    a_unmapped_err: assert property (
        (psel && penable && !st_reg.pready && !hit) |=> pslverr && (prdata == '0))
        else $error("unmapped access not refused");

endmodule // gpls_port

// ===== pkg/gpls_mux_if.sv
`timescale 1ns/1ps
interface gpls_mux_if;
    logic [3:0]                 segField;
    logic [gpls_pkg::PINS-1:0] gpioMode;

    modport ctrl (output segField, input gpioMode);
    modport mux  (input segField, output gpioMode);
endinterface

// ===== pkg/gpls_pkg.sv
package gpls_pkg;

    // ------------------------------------------------------------------
    // Port size and bus geometry
    // ------------------------------------------------------------------
    localparam int PINS   = 8;
    localparam int HALF   = 4;
    localparam int ADDR_W = 18;
    localparam int IDX_W  = 16;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_DATA   = 16'hffd9;
    localparam logic [IDX_W-1:0] IDX_PULLUP = 16'hffe3;
    localparam logic [IDX_W-1:0] IDX_DIR    = 16'hffe9;
    localparam logic [1:0]       WORD_LANE  = 2'h0;

    // ------------------------------------------------------------------
    // Reset and read-back values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [7:0]  DIR_READ   = 8'hff;
    localparam logic [31:0] READ_ZERO  = 32'h00000000;

    // ------------------------------------------------------------------
    // Segment-select ranges that hand a pin half to the display
    // ------------------------------------------------------------------
    localparam logic [3:0] SEG_UP_LO  = 4'h4;
    localparam logic [3:0] SEG_UP_HI  = 4'hb;
    localparam logic [3:0] SEG_LOW_LO = 4'h3;
    localparam logic [3:0] SEG_LOW_HI = 4'ha;
    localparam int         SEG_OFFSET = 9;

    // ------------------------------------------------------------------
    // Operating modes and bus states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GPLS_ACTIVE    = 3'h0,
        GPLS_SUBACTIVE = 3'h1,
        GPLS_SLEEP     = 3'h2,
        GPLS_SUBSLEEP  = 3'h3,
        GPLS_STANDBY   = 3'h4,
        GPLS_WATCH     = 3'h5
    } gpls_mode_t;

    typedef enum logic {
        GPLS_IDLE = 1'b0,
        GPLS_RESP = 1'b1
    } gpls_bus_t;

endpackage

// ===== tb/gpls_board.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Board circuitry seen by the port pins
// ------------------------------------------------------------------
module gpls_board (
    input  wire logic       clk,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullupOn,
    input  wire logic [7:0] drvEn,
    input  wire logic [7:0] drvVal,
    output logic      [7:0] pinIn
);
    logic [7:0] lastLevel = 8'h00;

    // A floating line shows the inverse of its last level, so that a read of
    // an undriven pin never matches by luck.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pinOe[i])
                pinIn[i] = pinOut[i];
            else if (drvEn[i])
                pinIn[i] = drvVal[i];
            else if (pullupOn[i])
                pinIn[i] = 1'b1;
            else
                pinIn[i] = ~lastLevel[i];
        end
    end

    always_ff @(posedge clk)
    begin
        lastLevel <= pinIn;
    end
endmodule // gpls_board

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  segField = 4'h0;
    logic [2:0]  powerMode = 3'h0;
    logic [7:0]  segData = 8'h00;
    logic [7:0]  pinIn, pinOut, pinOe, pullupOn;
    logic [7:0]  drvEn = 8'hff;
    logic [7:0]  drvVal = 8'h5a;
    logic [31:0] rd;
    logic        er;
    int          nMismatch = 0;
    int          nCompared = 0;
    int          cycles = 0;
    localparam logic [17:0] A_DATA = {gpls_pkg::IDX_DATA, 2'h0};
    localparam logic [17:0] A_PU   = {gpls_pkg::IDX_PULLUP, 2'h0};
    localparam logic [17:0] A_DIR  = {gpls_pkg::IDX_DIR, 2'h0};

    always #50 clk = ~clk;

    gpls_port dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .segField(segField), .powerMode(powerMode), .segData(segData), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn));

    gpls_board board_u (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
        .drvEn(drvEn), .drvVal(drvVal), .pinIn(pinIn));

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout may end this wait.
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pinChk(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
        repeat (2) @(posedge clk);
        #1;
        `CHK("pinOe", oe, pinOe)
        `CHK("pinOut", out, pinOut)
        `CHK("pullupOn", pu, pullupOn)
        // Realign so that the next stimulus lands on a rising edge.
        @(posedge clk);
    endtask

    function automatic logic [7:0] ioMask(input logic [3:0] f);
        ioMask[7:4] = (f >= 4'h4 && f <= 4'hb) ? 4'h0 : 4'hf;
        ioMask[3:0] = (f >= 4'h3 && f <= 4'ha) ? 4'h0 : 4'hf;
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        pinChk(8'h00, 8'h00, 8'h00);
        apb(1'b0, A_DATA, 32'h0);
        `CHK("data read", 32'h0000005a, rd)
        apb(1'b0, A_PU, 32'h0);
        `CHK("pullup reset", 32'h00000000, rd)
        apb(1'b0, A_DIR, 32'h0);
        `CHK("dir read", 32'h000000ff, rd)
        $display("test reset done");
    endtask

    task automatic t_dirdata();
        drvVal <= 8'h3c;
        apb(1'b1, A_DIR, 32'hffffff0f);
        apb(1'b1, A_DATA, 32'h000000a5);
        #1;
        `CHK("pinOut at write", 8'ha5, pinOut)
        apb(1'b0, A_DATA, 32'h0);
        `CHK("mixed read", 32'h00000035, rd)
        apb(1'b0, A_DIR, 32'h0);
        `CHK("dir read", 32'h000000ff, rd)
        apb(1'b1, A_PU, 32'h000000ff);
        apb(1'b0, A_PU, 32'h0);
        `CHK("pullup read", 32'h000000ff, rd)
        pinChk(8'h0f, 8'ha5, 8'hf0);
        drvEn <= 8'h00;
        apb(1'b0, A_DATA, 32'h0);
        `CHK("pulled read", 32'h000000f5, rd)
        $display("test direction and data done");
    endtask

    task automatic t_segment();
        logic [7:0] io;
        segData <= 8'h96;
        for (int f = 0; f < 16; f++)
        begin
            segField <= f[3:0];
            io = ioMask(f[3:0]);
            pinChk((io & 8'h0f) | ~io, (io & 8'ha5) | (~io & 8'h96), io & 8'hf0);
        end
        segField <= 4'h0;
        $display("test segment done");
    endtask

    task automatic t_modes();
        powerMode <= gpls_pkg::GPLS_SLEEP;
        pinChk(8'h0f, 8'ha5, 8'hf0);
        apb(1'b1, A_DATA, 32'h0000005a);
        // Sleep holds the old pin level, so output bits must read the latch.
        apb(1'b0, A_DATA, 32'h0);
        `CHK("latch over pin", 32'h000000fa, rd)
        segField <= 4'h4;
        pinChk(8'h0f, 8'ha5, 8'hf0);
        segField <= 4'h0;
        for (int m = 4; m < 8; m++)
        begin
            powerMode <= m[2:0];
            pinChk(8'h00, 8'h00, 8'hf0);
        end
        powerMode <= gpls_pkg::GPLS_SUBACTIVE;
        pinChk(8'h0f, 8'h5a, 8'hf0);
        powerMode <= gpls_pkg::GPLS_ACTIVE;
        apb(1'b0, 18'h3ff68, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, A_DATA + 18'h1, 32'h0);
        `CHK("misaligned err", 1'b1, er)
        pinChk(8'h0f, 8'h5a, 8'hf0);
        $display("test modes done");
    endtask

    task automatic t_rerun();
        @(posedge clk);
        rst <= 1'b1;
        pinChk(8'h00, 8'h00, 8'h00);
        rst <= 1'b0;
        drvEn <= 8'hff;
        drvVal <= 8'h33;
        apb(1'b0, A_DATA, 32'h0);
        `CHK("input after reset", 32'h00000033, rd)
        apb(1'b1, A_DIR, 32'h000000ff);
        apb(1'b0, A_DATA, 32'h0);
        `CHK("latch after reset", 32'h00000000, rd)
        $display("test second reset done");
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // The whole run needs about 160 cycles; the ceiling leaves ample room.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            nMismatch++;
            test_done();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_dirdata();
        t_segment();
        t_modes();
        t_rerun();
        test_done();
    end
endmodule // tb_top
